//--- shared/channel_clock_dividers_regs.vh
// register offsets, field positions and reset values of the channel clock dividers
`ifndef CHANNEL_CLOCK_DIVIDERS_REGS_VH
`define CHANNEL_CLOCK_DIVIDERS_REGS_VH

`define CHAN0_PHASE_COUNTS    9'h190
`define CHAN0_DELAY_SETUP     9'h191
`define CHAN1_PHASE_COUNTS    9'h196
`define CHAN1_DELAY_SETUP     9'h197
`define CHAN2_STAGE1_COUNTS   9'h199
`define CHAN2_STAGE2_COUNTS   9'h19b
`define CHAN2_BYPASS_CTRL     9'h19c
`define CHAN2_CORRECTION_CTRL 9'h19d
`define CHAN3_STAGE1_COUNTS   9'h19e
`define CHAN3_STAGE2_COUNTS   9'h1a0
`define CHAN3_BYPASS_CTRL     9'h1a1
`define CHAN3_CORRECTION_CTRL 9'h1a2
`define OUTPUT_MODE_CTRL      9'h1f0
`define OUTPUT_LEVEL_STATUS   9'h1f1
`define RESYNC_CMD            9'h1f2

`define LOW_COUNT_MSB         7
`define LOW_COUNT_LSB         4
`define HIGH_COUNT_MSB        3
`define HIGH_COUNT_LSB        0
`define DIV01_BYPASS_BIT      7
`define INITIAL_LEVEL_BIT     4
`define COARSE_DELAY_MSB      3
`define COARSE_DELAY_LSB      0
`define STAGE1_BYPASS_BIT     4
`define STAGE2_BYPASS_BIT     5
`define DUTY_FIX_DISABLE_BIT  0
`define SE_MODE_LSB           0
`define B_ENABLE_LSB          4

`define COUNTS_RESET          8'h00
`define DELAY_SETUP_RESET     8'h00
`define BYPASS_CTRL_RESET     8'h00
`define CORRECTION_CTRL_RESET 8'h00
`define OUTPUT_MODE_RESET     8'h00
`define OFFSET_WRAP           5'h10

`endif

//--- design/channel_clock_dividers.v
// channel clock dividers: two single-stage and two cascaded-stage channels with register port
// Functional notes
// (R1) channels 0/1 offset: initial level bit weighs 16, coarse delay bits 8,4,2,1
// (R2) offset up to 15 delays that many cycles; else offset-16+low count+1
// (R3) high count sets high phase, low count sets low phase, in input cycles
// (R4) each count field holds cycles minus one
// (R5) channels 2/3 drive two differential outputs, each splittable into A and B
// (R6) B single-ended output stays off after reset until enabled
// (R7) channels 2/3 cascade two 2-to-32 stages, product up to 1024
// (R8) stage bypass bits 4 and 5 give ratio one
// (R9) both bypassed gives 1; second bypassed gives first ratio; else product
// (R10) software uses first stage alone, never second stage alone
// (R11) duty fix on by default; bit 0 disables it for both stages
// (R12) software sets equal counts for even ratio, low one above high for odd
// (R13) with duty fix, lone bypassed or lone even stage must be second
// (R14) duty fix off: last active stage gives high+1 over high+low+2
// (R15) duty fix off, both bypassed: output follows input clock duty
// (R16) software issues a sync after changing coarse offsets
// (R17) channels 0/1 divide by high+low+2, or exactly one when bypassed
// (R18) each stage counts input rising edges, high phase then low, repeating
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
`include "channel_clock_dividers_regs.vh"

module div_stage (
  input  wire       sys_clk,
  input  wire       srst,
  input  wire       restart,
  input  wire       tick_r,
  input  wire       tick_f,
  input  wire       in_lvl,
  input  wire [3:0] lo_cnt,
  input  wire [3:0] hi_cnt,
  input  wire       bypass,
  input  wire       fix,
  input  wire [4:0] delay,
  output reg        out_lvl,
  output reg        out_r,
  output reg        out_f
);
  localparam ST_WAIT = 3'b001;
  localparam ST_HIGH = 3'b010;
  localparam ST_LOW  = 3'b100;

  reg [2:0] state;
  reg [4:0] cnt;
  reg       half;
  wire      odd_fix;

  // odd ratio with low one above high: stretch high by half an input cycle
  assign odd_fix = fix && ({1'b0, lo_cnt} == {1'b0, hi_cnt} + 5'h01);

  always @(posedge sys_clk) begin
    if (srst || restart) begin
      state   <= ST_WAIT;
      cnt     <= 5'h00;
      half    <= 1'b0;
      out_lvl <= 1'b0;
      out_r   <= 1'b0;
      out_f   <= 1'b0;
    end else begin
      out_r <= 1'b0;
      out_f <= 1'b0;
      if (bypass) begin
        out_lvl <= in_lvl; // (R8)
        out_r   <= tick_r; // (R15)
        out_f   <= tick_f;
      end else begin
        case (state)
          ST_WAIT: begin
            if (tick_r) begin
              if (cnt == delay) begin
                state   <= ST_HIGH; // (R2)
                cnt     <= 5'h00;
                out_lvl <= 1'b1;
                out_r   <= 1'b1;
              end else begin
                cnt <= cnt + 5'h01;
              end
            end
          end
          ST_HIGH: begin
            if (half) begin
              if (tick_f) begin
                state   <= ST_LOW; // (R11)
                half    <= 1'b0;
                cnt     <= 5'h00;
                out_lvl <= 1'b0;
                out_f   <= 1'b1;
              end
            end else if (tick_r) begin
              if (cnt == {1'b0, hi_cnt}) begin // (R3) (R4) (R18)
                if (odd_fix) begin
                  half <= 1'b1;
                end else begin
                  state   <= ST_LOW; // (R14)
                  cnt     <= 5'h00;
                  out_lvl <= 1'b0;
                  out_f   <= 1'b1;
                end
              end else begin
                cnt <= cnt + 5'h01;
              end
            end
          end
          ST_LOW: begin
            if (tick_r) begin
              if (cnt == {1'b0, lo_cnt}) begin // (R3) (R4) (R18)
                state   <= ST_HIGH;
                cnt     <= 5'h00;
                out_lvl <= 1'b1;
                out_r   <= 1'b1;
              end else begin
                cnt <= cnt + 5'h01;
              end
            end
          end
          default: begin
            state <= ST_WAIT;
          end
        endcase
      end
    end
  end
endmodule

module channel_clock_dividers (
  input  wire       sys_clk,
  input  wire       srst,
  input  wire       div_clk_in,
  input  wire [8:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  output reg        chan0_out,
  output reg        chan1_out,
  output reg        chan2_diff_out_a_p,
  output reg        chan2_diff_out_a_n,
  output reg        chan2_diff_out_b_p,
  output reg        chan2_diff_out_b_n,
  output reg        chan3_diff_out_a_p,
  output reg        chan3_diff_out_a_n,
  output reg        chan3_diff_out_b_p,
  output reg        chan3_diff_out_b_n
);
  reg  [7:0] chan0_phase_counts;
  reg  [7:0] chan0_delay_setup;
  reg  [7:0] chan1_phase_counts;
  reg  [7:0] chan1_delay_setup;
  reg  [7:0] chan2_stage1_counts;
  reg  [7:0] chan2_stage2_counts;
  reg  [7:0] chan2_bypass_ctrl;
  reg  [7:0] chan2_correction_ctrl;
  reg  [7:0] chan3_stage1_counts;
  reg  [7:0] chan3_stage2_counts;
  reg  [7:0] chan3_bypass_ctrl;
  reg  [7:0] chan3_correction_ctrl;
  reg  [7:0] output_mode;
  reg        resync;
  reg        in_sync1;
  reg        in_sync2;
  reg        in_prev;
  reg  [7:0] next_rdata;
  wire       in_rise;
  wire       in_fall;
  wire       ch0_lvl;
  wire       ch1_lvl;
  wire       c2s1_lvl;
  wire       c2s1_r;
  wire       c2s1_f;
  wire       c2_lvl;
  wire       c3s1_lvl;
  wire       c3s1_r;
  wire       c3s1_f;
  wire       c3_lvl;

  // five-bit offset and resulting delay in input cycles
  function [4:0] coarse_delay;
    input [7:0] setup;
    input [3:0] lo;
    reg   [4:0] phi;
    begin
      phi = {setup[`INITIAL_LEVEL_BIT], setup[`COARSE_DELAY_MSB:`COARSE_DELAY_LSB]}; // (R1)
      if (phi < `OFFSET_WRAP)
        coarse_delay = phi; // (R2)
      else
        coarse_delay = phi - `OFFSET_WRAP + {1'b0, lo} + 5'h01; // (R2)
    end
  endfunction

  // complement in differential mode; in single-ended mode B only when enabled
  function pin_b;
    input lvl;
    input se;
    input b_en;
    begin
      pin_b = se ? (b_en & lvl) : ~lvl; // (R5) (R6)
    end
  endfunction

  // input clock from outside: two flops before any use
  always @(posedge sys_clk) begin
    in_sync1 <= div_clk_in;
    in_sync2 <= in_sync1;
    in_prev  <= in_sync2;
  end
  assign in_rise = in_sync2 & ~in_prev;
  assign in_fall = ~in_sync2 & in_prev;

  always @(posedge sys_clk) begin
    if (srst) begin
      chan0_phase_counts    <= `COUNTS_RESET;
      chan0_delay_setup     <= `DELAY_SETUP_RESET;
      chan1_phase_counts    <= `COUNTS_RESET;
      chan1_delay_setup     <= `DELAY_SETUP_RESET;
      chan2_stage1_counts   <= `COUNTS_RESET;
      chan2_stage2_counts   <= `COUNTS_RESET;
      chan2_bypass_ctrl     <= `BYPASS_CTRL_RESET;
      chan2_correction_ctrl <= `CORRECTION_CTRL_RESET; // (R11)
      chan3_stage1_counts   <= `COUNTS_RESET;
      chan3_stage2_counts   <= `COUNTS_RESET;
      chan3_bypass_ctrl     <= `BYPASS_CTRL_RESET;
      chan3_correction_ctrl <= `CORRECTION_CTRL_RESET; // (R11)
      output_mode           <= `OUTPUT_MODE_RESET; // (R6)
      resync                <= 1'b0;
    end else begin
      resync <= reg_wr && (reg_addr == `RESYNC_CMD);
      if (reg_wr) begin
        case (reg_addr)
          `CHAN0_PHASE_COUNTS:    chan0_phase_counts    <= reg_wdata;
          `CHAN0_DELAY_SETUP:     chan0_delay_setup     <= reg_wdata;
          `CHAN1_PHASE_COUNTS:    chan1_phase_counts    <= reg_wdata;
          `CHAN1_DELAY_SETUP:     chan1_delay_setup     <= reg_wdata;
          `CHAN2_STAGE1_COUNTS:   chan2_stage1_counts   <= reg_wdata;
          `CHAN2_STAGE2_COUNTS:   chan2_stage2_counts   <= reg_wdata;
          `CHAN2_BYPASS_CTRL:     chan2_bypass_ctrl     <= reg_wdata;
          `CHAN2_CORRECTION_CTRL: chan2_correction_ctrl <= reg_wdata;
          `CHAN3_STAGE1_COUNTS:   chan3_stage1_counts   <= reg_wdata;
          `CHAN3_STAGE2_COUNTS:   chan3_stage2_counts   <= reg_wdata;
          `CHAN3_BYPASS_CTRL:     chan3_bypass_ctrl     <= reg_wdata;
          `CHAN3_CORRECTION_CTRL: chan3_correction_ctrl <= reg_wdata;
          `OUTPUT_MODE_CTRL:      output_mode           <= reg_wdata;
          default: begin
          end
        endcase
      end
    end
  end

  always @* begin
    next_rdata = 8'h00;
    case (reg_addr)
      `CHAN0_PHASE_COUNTS:    next_rdata = chan0_phase_counts;
      `CHAN0_DELAY_SETUP:     next_rdata = chan0_delay_setup;
      `CHAN1_PHASE_COUNTS:    next_rdata = chan1_phase_counts;
      `CHAN1_DELAY_SETUP:     next_rdata = chan1_delay_setup;
      `CHAN2_STAGE1_COUNTS:   next_rdata = chan2_stage1_counts;
      `CHAN2_STAGE2_COUNTS:   next_rdata = chan2_stage2_counts;
      `CHAN2_BYPASS_CTRL:     next_rdata = chan2_bypass_ctrl;
      `CHAN2_CORRECTION_CTRL: next_rdata = chan2_correction_ctrl;
      `CHAN3_STAGE1_COUNTS:   next_rdata = chan3_stage1_counts;
      `CHAN3_STAGE2_COUNTS:   next_rdata = chan3_stage2_counts;
      `CHAN3_BYPASS_CTRL:     next_rdata = chan3_bypass_ctrl;
      `CHAN3_CORRECTION_CTRL: next_rdata = chan3_correction_ctrl;
      `OUTPUT_MODE_CTRL:      next_rdata = output_mode;
      `OUTPUT_LEVEL_STATUS:   next_rdata = {4'h0, c3_lvl, c2_lvl, ch1_lvl, ch0_lvl};
      default:                next_rdata = 8'h00;
    endcase
  end

  always @(posedge sys_clk) begin
    if (srst)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_rd ? next_rdata : 8'h00;
  end

  // channels 0 and 1: single stage with coarse offset
  div_stage u_ch0 (
    .sys_clk (sys_clk),
    .srst    (srst),
    .restart (resync),
    .tick_r  (in_rise),
    .tick_f  (in_fall),
    .in_lvl  (in_sync2),
    .lo_cnt  (chan0_phase_counts[`LOW_COUNT_MSB:`LOW_COUNT_LSB]),
    .hi_cnt  (chan0_phase_counts[`HIGH_COUNT_MSB:`HIGH_COUNT_LSB]),
    .bypass  (chan0_delay_setup[`DIV01_BYPASS_BIT]), // (R17)
    .fix     (1'b0),
    .delay   (coarse_delay(chan0_delay_setup, chan0_phase_counts[`LOW_COUNT_MSB:`LOW_COUNT_LSB])),
    .out_lvl (ch0_lvl),
    .out_r   (),
    .out_f   ()
  );

  div_stage u_ch1 (
    .sys_clk (sys_clk),
    .srst    (srst),
    .restart (resync),
    .tick_r  (in_rise),
    .tick_f  (in_fall),
    .in_lvl  (in_sync2),
    .lo_cnt  (chan1_phase_counts[`LOW_COUNT_MSB:`LOW_COUNT_LSB]),
    .hi_cnt  (chan1_phase_counts[`HIGH_COUNT_MSB:`HIGH_COUNT_LSB]),
    .bypass  (chan1_delay_setup[`DIV01_BYPASS_BIT]), // (R17)
    .fix     (1'b0),
    .delay   (coarse_delay(chan1_delay_setup, chan1_phase_counts[`LOW_COUNT_MSB:`LOW_COUNT_LSB])),
    .out_lvl (ch1_lvl),
    .out_r   (),
    .out_f   ()
  );

  // channels 2 and 3: second stage runs on first stage edges
  div_stage u_c2s1 (
    .sys_clk (sys_clk),
    .srst    (srst),
    .restart (resync),
    .tick_r  (in_rise),
    .tick_f  (in_fall),
    .in_lvl  (in_sync2),
    .lo_cnt  (chan2_stage1_counts[`LOW_COUNT_MSB:`LOW_COUNT_LSB]),
    .hi_cnt  (chan2_stage1_counts[`HIGH_COUNT_MSB:`HIGH_COUNT_LSB]),
    .bypass  (chan2_bypass_ctrl[`STAGE1_BYPASS_BIT]), // (R8)
    .fix     (~chan2_correction_ctrl[`DUTY_FIX_DISABLE_BIT]), // (R11)
    .delay   (5'h00),
    .out_lvl (c2s1_lvl),
    .out_r   (c2s1_r),
    .out_f   (c2s1_f)
  );

  div_stage u_c2s2 (
    .sys_clk (sys_clk),
    .srst    (srst),
    .restart (resync),
    .tick_r  (c2s1_r), // (R7) (R9)
    .tick_f  (c2s1_f),
    .in_lvl  (c2s1_lvl),
    .lo_cnt  (chan2_stage2_counts[`LOW_COUNT_MSB:`LOW_COUNT_LSB]),
    .hi_cnt  (chan2_stage2_counts[`HIGH_COUNT_MSB:`HIGH_COUNT_LSB]),
    .bypass  (chan2_bypass_ctrl[`STAGE2_BYPASS_BIT]), // (R8)
    .fix     (~chan2_correction_ctrl[`DUTY_FIX_DISABLE_BIT]), // (R11)
    .delay   (5'h00),
    .out_lvl (c2_lvl),
    .out_r   (),
    .out_f   ()
  );

  div_stage u_c3s1 (
    .sys_clk (sys_clk),
    .srst    (srst),
    .restart (resync),
    .tick_r  (in_rise),
    .tick_f  (in_fall),
    .in_lvl  (in_sync2),
    .lo_cnt  (chan3_stage1_counts[`LOW_COUNT_MSB:`LOW_COUNT_LSB]),
    .hi_cnt  (chan3_stage1_counts[`HIGH_COUNT_MSB:`HIGH_COUNT_LSB]),
    .bypass  (chan3_bypass_ctrl[`STAGE1_BYPASS_BIT]), // (R8)
    .fix     (~chan3_correction_ctrl[`DUTY_FIX_DISABLE_BIT]), // (R11)
    .delay   (5'h00),
    .out_lvl (c3s1_lvl),
    .out_r   (c3s1_r),
    .out_f   (c3s1_f)
  );

  div_stage u_c3s2 (
    .sys_clk (sys_clk),
    .srst    (srst),
    .restart (resync),
    .tick_r  (c3s1_r), // (R7) (R9)
    .tick_f  (c3s1_f),
    .in_lvl  (c3s1_lvl),
    .lo_cnt  (chan3_stage2_counts[`LOW_COUNT_MSB:`LOW_COUNT_LSB]),
    .hi_cnt  (chan3_stage2_counts[`HIGH_COUNT_MSB:`HIGH_COUNT_LSB]),
    .bypass  (chan3_bypass_ctrl[`STAGE2_BYPASS_BIT]), // (R8)
    .fix     (~chan3_correction_ctrl[`DUTY_FIX_DISABLE_BIT]), // (R11)
    .delay   (5'h00),
    .out_lvl (c3_lvl),
    .out_r   (),
    .out_f   ()
  );

  // output pins: mode bits per output, B enable per output
  always @(posedge sys_clk) begin
    if (srst) begin
      chan0_out          <= 1'b0;
      chan1_out          <= 1'b0;
      chan2_diff_out_a_p <= 1'b0;
      chan2_diff_out_a_n <= 1'b0;
      chan2_diff_out_b_p <= 1'b0;
      chan2_diff_out_b_n <= 1'b0;
      chan3_diff_out_a_p <= 1'b0;
      chan3_diff_out_a_n <= 1'b0;
      chan3_diff_out_b_p <= 1'b0;
      chan3_diff_out_b_n <= 1'b0;
    end else begin
      chan0_out          <= ch0_lvl;
      chan1_out          <= ch1_lvl;
      chan2_diff_out_a_p <= c2_lvl; // (R5)
      chan2_diff_out_a_n <= pin_b(c2_lvl, output_mode[`SE_MODE_LSB], output_mode[`B_ENABLE_LSB]);
      chan2_diff_out_b_p <= c2_lvl;
      chan2_diff_out_b_n <= pin_b(c2_lvl, output_mode[`SE_MODE_LSB + 1], output_mode[`B_ENABLE_LSB + 1]);
      chan3_diff_out_a_p <= c3_lvl;
      chan3_diff_out_a_n <= pin_b(c3_lvl, output_mode[`SE_MODE_LSB + 2], output_mode[`B_ENABLE_LSB + 2]);
      chan3_diff_out_b_p <= c3_lvl;
      chan3_diff_out_b_n <= pin_b(c3_lvl, output_mode[`SE_MODE_LSB + 3], output_mode[`B_ENABLE_LSB + 3]);
    end
  end
endmodule

//--- verif/channel_clock_dividers_sva.sv
// assertion checker for the channel clock dividers
`timescale 1ns/1ns
`include "channel_clock_dividers_regs.vh"
module channel_clock_dividers_sva (
  input wire       sys_clk,
  input wire       srst,
  input wire       div_clk_in,
  input wire [8:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       chan0_out,
  input wire       chan2_diff_out_a_p,
  input wire       chan2_diff_out_a_n,
  input wire       chan2_diff_out_b_p,
  input wire       chan2_diff_out_b_n,
  input wire       chan3_diff_out_a_p,
  input wire       chan3_diff_out_a_n,
  input wire       chan3_diff_out_b_p,
  input wire       chan3_diff_out_b_n
);
  reg [7:0] mode;
  reg [7:0] cnts;
  reg       byp0;
  reg [9:0] age;
  reg       in_q;
  reg [4:0] hcnt;
  reg [4:0] lcnt;
  wire      rise    = div_clk_in & ~in_q;
  wire      steady  = age == 10'h3ff && !byp0;
  wire      settled = age > 10'h002;
  // input rises counted inside each chan0 phase; age since last write or reset
  always @(posedge sys_clk) begin
    if (srst) begin
      mode <= 8'h00;
      cnts <= 8'h00;
      byp0 <= 1'b0;
      age  <= 10'h000;
      in_q <= 1'b0;
      hcnt <= 5'h00;
      lcnt <= 5'h00;
    end else begin
      in_q <= div_clk_in;
      age  <= reg_wr ? 10'h000 : (age == 10'h3ff ? age : age + 10'h001);
      if (reg_wr && reg_addr == `OUTPUT_MODE_CTRL)
        mode <= reg_wdata;
      if (reg_wr && reg_addr == `CHAN0_PHASE_COUNTS)
        cnts <= reg_wdata;
      if (reg_wr && reg_addr == `CHAN0_DELAY_SETUP)
        byp0 <= reg_wdata[`DIV01_BYPASS_BIT];
      hcnt <= chan0_out ? hcnt + {4'h0, rise} : 5'h00;
      lcnt <= chan0_out ? 5'h00 : lcnt + {4'h0, rise};
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  hi_phase_a: assert property ($fell(chan0_out) && steady |-> hcnt == {1'b0, cnts[3:0]} + 5'h01)
    else $error("chan0 high phase length wrong");
  lo_phase_a: assert property ($rose(chan0_out) && steady |-> lcnt == {1'b0, cnts[7:4]} + 5'h01)
    else $error("chan0 low phase length wrong");
  a2_diff_a: assert property (settled && !mode[0] |-> chan2_diff_out_a_n == !chan2_diff_out_a_p)
    else $error("chan2 a pair not complementary");
  a3_diff_a: assert property (settled && !mode[2] |-> chan3_diff_out_a_n == !chan3_diff_out_a_p)
    else $error("chan3 a pair not complementary");
  b3_diff_a: assert property (settled && !mode[3] |-> chan3_diff_out_b_n == !chan3_diff_out_b_p)
    else $error("chan3 b pair not complementary");
  b2_off_a: assert property (settled && mode[1] && !mode[5] |-> !chan2_diff_out_b_n)
    else $error("chan2 b output active while off");
  b3_off_a: assert property (settled && mode[3] && !mode[7] |-> !chan3_diff_out_b_n)
    else $error("chan3 b output active while off");
  b2_on_a: assert property (settled && mode[1] && mode[5] |-> chan2_diff_out_b_n == chan2_diff_out_b_p)
    else $error("chan2 b output not following level");
endmodule

//--- verif/test_channel_clock_dividers.sv
// self-checking testbench for the channel clock dividers
`timescale 1ns/1ns
`include "channel_clock_dividers_regs.vh"
module test_channel_clock_dividers;
  reg          sys_clk;
  reg          srst;
  reg          div_clk_in;
  reg  [1:0]   dcnt;
  reg  [8:0]   reg_addr;
  reg  [7:0]   reg_wdata;
  reg          reg_wr;
  reg          reg_rd;
  wire [7:0]   reg_rdata;
  wire         c0;
  wire         c1;
  wire [3:0]   lp;
  wire [3:0]   ln;
  wire [3:0]   lv = {lp[2], lp[0], c1, c0};
  integer      errors;
  integer      comparisons;
  integer      seed;
  integer      i;
  integer      ch;
  integer      h;
  integer      p;
  integer      n;
  integer      c;
  integer      rn;
  integer      r1;
  integer      r2;
  integer      eh;
  reg  [7:0]   v;
  reg  [31:0]  e;
  reg  [8:0]   b;
  localparam [134:0] adrs = {9'h1ff, 9'h1f2, 9'h1f0, 9'h1a2, 9'h1a1, 9'h1a0, 9'h19e, 9'h19d, 9'h19c,
                             9'h19b, 9'h199, 9'h197, 9'h196, 9'h191, 9'h190};
  // per entry: stage1 counts, stage2 counts, bypass, correction
  localparam [159:0] tbl = {32'h10002001, 32'h10002000, 32'h11210001, 32'h11003001, 32'h11002001};
  localparam [31:0]  modes = {8'h5a, 8'hff, 8'h0f, 8'h00};

  channel_clock_dividers dut (
    .sys_clk            (sys_clk),
    .srst               (srst),
    .div_clk_in         (div_clk_in),
    .reg_addr           (reg_addr),
    .reg_wdata          (reg_wdata),
    .reg_wr             (reg_wr),
    .reg_rd             (reg_rd),
    .reg_rdata          (reg_rdata),
    .chan0_out          (c0),
    .chan1_out          (c1),
    .chan2_diff_out_a_p (lp[0]),
    .chan2_diff_out_a_n (ln[0]),
    .chan2_diff_out_b_p (lp[1]),
    .chan2_diff_out_b_n (ln[1]),
    .chan3_diff_out_a_p (lp[2]),
    .chan3_diff_out_a_n (ln[2]),
    .chan3_diff_out_b_p (lp[3]),
    .chan3_diff_out_b_n (ln[3])
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // divider input clock: eight system cycles a period
  always @(posedge sys_clk) begin
    dcnt <= dcnt + 2'd1;
    if (dcnt == 2'd3)
      div_clk_in <= ~div_clk_in;
  end

  function integer ratio(input [7:0] cv);
    ratio = cv[7:4] + cv[3:0] + 2;
  endfunction
  function integer dly(input [4:0] f, input [3:0] lo);
    dly = (f < 16) ? f : f - 16 + lo + 1;
  endfunction
  function [3:0] exp_n(input [7:0] m, input [3:0] pv);
    integer j;
    for (j = 0; j < 4; j = j + 1)
      exp_n[j] = m[j] ? (pv[j] & m[j + 4]) : ~pv[j];
  endfunction

  task chk(input [15:0] got, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("comparisons=%0d errors=%0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task wr(input [8:0] a, input [7:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
    end
  endtask
  task rd(input [8:0] a, input [7:0] x);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, x);
      @(posedge sys_clk);
    end
  endtask
  // bounded wait for a level on one output, counting the cycles spent
  task wl(input integer k, input lvl, inout integer nn, inout integer cc);
    begin
      while (lv[k] !== lvl && nn < 3000) begin
        @(posedge sys_clk);
        nn = nn + 1;
        cc = cc + 1;
      end
      if (nn >= 3000) begin
        errors = errors + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, lv[k], lvl);
        report_and_stop;
      end
    end
  endtask
  task meas(input integer k, output integer hh, output integer pp);
    integer dm;
    begin
      n = 0;
      dm = 0;
      hh = 0;
      repeat (2) begin
        wl(k, 1'b0, n, dm);
        wl(k, 1'b1, n, dm);
      end
      wl(k, 1'b0, n, hh);
      pp = hh;
      wl(k, 1'b1, n, pp);
    end
  endtask

  initial begin
    seed = 30;
    errors = 0;
    comparisons = 0;
    srst = 1'b1;
    div_clk_in = 1'b0;
    dcnt = 2'd0;
    reg_addr = 9'h000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    for (i = 0; i < 15; i = i + 1)
      rd(adrs[i * 9 +: 9], 8'h00);
    for (i = 0; i < 13; i = i + 1) begin
      rn = $random(seed);
      wr(adrs[i * 9 +: 9], rn[7:0]);
      rd(adrs[i * 9 +: 9], rn[7:0]);
    end
    rd(9'h1f2, 8'h00);
    rd(9'h1ff, 8'h00);
    $display("test registers done");
    for (i = 0; i < 5; i = i + 1) begin
      rn = $random(seed);
      v = rn[7:0];
      wr(`CHAN0_PHASE_COUNTS, v);
      wr(`CHAN0_DELAY_SETUP, (i == 4) ? 8'h80 : 8'h00);
      wr(`RESYNC_CMD, 8'h00);
      meas(0, h, p);
      chk(p, (i == 4) ? 8 : ratio(v) * 8);
      chk(h, (i == 4) ? 4 : (v[3:0] + 1) * 8);
    end
    $display("test single stage done");
    wr(`CHAN0_PHASE_COUNTS, 8'h33);
    wr(`CHAN0_DELAY_SETUP, 8'h00);
    wr(`CHAN1_PHASE_COUNTS, 8'h33);
    for (i = 0; i < 2; i = i + 1) begin
      v = i ? 8'h13 : 8'h05;
      wr(`CHAN1_DELAY_SETUP, v);
      wr(`RESYNC_CMD, 8'h00);
      repeat (100) @(posedge sys_clk);
      n = 0;
      wl(0, 1'b0, n, c);
      wl(0, 1'b1, n, c);
      c = 0;
      wl(1, 1'b0, n, c);
      wl(1, 1'b1, n, c);
      chk(c, dly(v[4:0], 4'h3) * 8);
    end
    $display("test coarse offset done");
    for (ch = 2; ch < 4; ch = ch + 1) begin
      for (i = 0; i < 5; i = i + 1) begin
        e = tbl[i * 32 +: 32];
        b = (ch == 2) ? 9'h199 : 9'h19e;
        wr(b, e[31:24]);
        wr(b + 9'h002, e[23:16]);
        wr(b + 9'h003, e[15:8]);
        wr(b + 9'h004, e[7:0]);
        wr(`RESYNC_CMD, 8'h00);
        meas(ch, h, p);
        r1 = e[12] ? 1 : ratio(e[31:24]);
        r2 = e[13] ? 1 : ratio(e[23:16]);
        if (!e[0])
          eh = r1 * r2 * 4;
        else if (!e[13])
          eh = (e[19:16] + 1) * r1 * 8;
        else if (!e[12])
          eh = (e[27:24] + 1) * 8;
        else
          eh = 4;
        chk(p, r1 * r2 * 8);
        chk(h, eh);
      end
    end
    $display("test cascade done");
    for (i = 0; i < 5; i = i + 1) begin
      rn = $random(seed);
      v = (i < 4) ? modes[i * 8 +: 8] : rn[7:0];
      wr(`OUTPUT_MODE_CTRL, v);
      rd(`OUTPUT_MODE_CTRL, v);
      // live levels: status data and pins launched by the same edge
      reg_addr <= `OUTPUT_LEVEL_STATUS;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, {4'h0, lv});
      repeat (20) begin
        @(posedge sys_clk);
        chk(ln, exp_n(v, lp));
        chk({lp[3], lp[1]}, {lp[2], lp[0]});
      end
    end
    $display("test output modes done");
    repeat (1200) @(posedge sys_clk);
    report_and_stop;
  end
endmodule

bind channel_clock_dividers channel_clock_dividers_sva u_sva (
  .sys_clk            (sys_clk),
  .srst               (srst),
  .div_clk_in         (div_clk_in),
  .reg_addr           (reg_addr),
  .reg_wdata          (reg_wdata),
  .reg_wr             (reg_wr),
  .chan0_out          (chan0_out),
  .chan2_diff_out_a_p (chan2_diff_out_a_p),
  .chan2_diff_out_a_n (chan2_diff_out_a_n),
  .chan2_diff_out_b_p (chan2_diff_out_b_p),
  .chan2_diff_out_b_n (chan2_diff_out_b_n),
  .chan3_diff_out_a_p (chan3_diff_out_a_p),
  .chan3_diff_out_a_n (chan3_diff_out_a_n),
  .chan3_diff_out_b_p (chan3_diff_out_b_p),
  .chan3_diff_out_b_n (chan3_diff_out_b_n)
);
